// ### src/ccdt_seq.sv
// Readout timing generator for a four-quadrant charge-multiplying image sensor
`timescale 1ns/100ps
`include "ccdt_consts.svh"

// ----------------------------------------------------------------------------
// Pixel FIFO
// ----------------------------------------------------------------------------
module ccdt_fifo #(
  parameter int W = 34,
  parameter int D = 16
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          wr, rd;

  always_comb begin
    in_ready  = (cnt_r != (AW+1)'(D));
    out_valid = (cnt_r != '0);
    out_data  = mem[rp_r];
    wr        = in_valid & in_ready;
    rd        = out_valid & out_ready;
    wp_nxt    = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt    = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : ccdt_fifo

// ----------------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------------
module ccdt_seq (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire ccdt_pkg::ccdt_mode_t mode,
  input  wire logic                shutter_en,
  input  wire logic                long_int,
  input  wire logic                reverse_a,
  input  wire logic                reverse_b,
  input  wire logic [15:0]         threshold,
  input  wire logic [15:0]         exposure_lines,
  input  wire logic [15:0]         fg_adc,
  input  wire logic [15:0]         norm_adc,
  input  wire logic [15:0]         mult_adc,
  input  wire logic                out_ready,
  output logic                     out_valid,
  output logic [33:0]              out_data,
  output logic                     first_storage_phase,
  output logic                     second_storage_phase,
  output logic                     first_barrier_phase_a,
  output logic                     second_barrier_phase_a,
  output logic                     first_barrier_phase_b,
  output logic                     second_barrier_phase_b,
  output logic                     upper_storage_one,
  output logic                     upper_storage_two,
  output logic                     upper_barrier_one,
  output logic                     upper_barrier_two,
  output logic                     charge_switch_phase,
  output logic                     route_normal_phase,
  output logic                     route_multiply_phase,
  output logic                     last_gate_phase,
  output logic                     exit_gate_phase,
  output logic                     first_multiply_storage_phase,
  output logic                     second_multiply_storage_phase,
  output logic                     first_multiply_barrier_phase,
  output logic                     second_multiply_barrier_phase,
  output logic [3:0]               vertical_phase,
  output logic                     transfer_pulse,
  output logic                     shutter_pulse,
  output logic                     clamp,
  output logic                     line_pattern_two,
  output logic                     amp_power_down,
  output logic                     substrate_reference_output_store,
  output logic                     multiply_flush,
  output logic                     busy,
  output logic                     frame_done,
  output logic                     overrun
);
  import ccdt_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [15:0] fg_m_r, fg_s_r, nm_m_r, nm_s_r, ml_m_r, ml_s_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fg_m_r <= '0; fg_s_r <= '0; nm_m_r <= '0;
      nm_s_r <= '0; ml_m_r <= '0; ml_s_r <= '0;
    end else begin
      fg_m_r <= fg_adc;   fg_s_r <= fg_m_r;
      nm_m_r <= norm_adc; nm_s_r <= nm_m_r;
      ml_m_r <= mult_adc; ml_s_r <= ml_m_r;
    end
  end

  // --------------------------------------------------------------------------
  // Frame and row sequencing
  // --------------------------------------------------------------------------
  ccdt_state_t st_r, st_nxt;
  logic [11:0] hcnt_r, hcnt_nxt, nh;
  logic [15:0] row_r, row_nxt, nv;
  logic [7:0]  tcnt_r, tcnt_nxt, seg_len;
  logic [1:0]  seg_r, seg_nxt;
  logic        hph_r, hph_nxt, tick, in_ready, single, done_nxt;

  always_comb begin
    single   = (mode != CCDT_DUAL) && (mode != CCDT_QUAD);
    nh       = single ? `CCDT_NH_SINGLE : `CCDT_NH_DUAL;
    nv       = single ? `CCDT_NV_SINGLE : `CCDT_NV_DUAL;
    seg_len  = seg_r[0] ? 8'(`CCDT_VB_CYC) : 8'(`CCDT_VA_CYC);
    tick     = hph_r;
    st_nxt   = st_r;
    hcnt_nxt = hcnt_r;
    row_nxt  = row_r;
    tcnt_nxt = tcnt_r + 8'd1;
    seg_nxt  = seg_r;
    done_nxt = 1'b0;
    hph_nxt  = ~hph_r;
    unique case (st_r)
      ST_IDLE: begin
        hph_nxt  = 1'b0;
        tcnt_nxt = '0;
        if (start) begin
          row_nxt = '0;
          st_nxt  = shutter_en ? ST_SHUT : ST_FXFER;
        end
      end
      ST_SHUT: begin
        hph_nxt = 1'b0;
        if (tcnt_r == 8'(`CCDT_SUB_CYC - 1)) begin
          st_nxt   = ST_EXPOSE;
          hcnt_nxt = '0;
          row_nxt  = '0;
        end
      end
      ST_EXPOSE, ST_FLUSH: begin
        if (tick) begin
          hcnt_nxt = hcnt_r + 12'd1;
          if (hcnt_r == nh - 12'd1) begin
            hcnt_nxt = '0;
            row_nxt  = row_r + 16'd1;
            if (st_r == ST_EXPOSE && row_r + 16'd1 >= exposure_lines) begin
              st_nxt  = long_int ? ST_FLUSH : ST_FXFER;
              row_nxt = '0;
            end else if (st_r == ST_FLUSH && row_r + 16'd1 >= `CCDT_FLUSH_ROWS) begin
              st_nxt  = ST_FXFER;
              row_nxt = '0;
            end
          end
        end
        tcnt_nxt = '0;
      end
      ST_FXFER: begin
        hph_nxt = 1'b0;
        if (tcnt_r == 8'(`CCDT_XFER_CYC - 1)) begin
          st_nxt   = ST_LXFER;
          tcnt_nxt = '0;
          seg_nxt  = '0;
          row_nxt  = '0;
        end
      end
      ST_LXFER: begin
        hph_nxt = 1'b0;
        if (tcnt_r == seg_len - 8'd1) begin
          tcnt_nxt = '0;
          seg_nxt  = seg_r + 2'd1;
          if (seg_r == 2'd3) begin
            st_nxt   = ST_ROW;
            hcnt_nxt = 12'd1;
          end
        end
      end
      ST_ROW: begin
        tcnt_nxt = '0;
        if (tick) begin
          if (hcnt_r != nh) begin
            hcnt_nxt = hcnt_r + 12'd1;
          end else if (row_r == nv - 16'd1) begin
            st_nxt   = ST_IDLE;
            done_nxt = 1'b1;
          end else if (in_ready) begin
            // Next row waits for FIFO room so back-pressure slows the frame
            st_nxt  = ST_LXFER;
            row_nxt = row_r + 16'd1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r   <= ST_IDLE;
      hcnt_r <= '0;
      row_r  <= '0;
      tcnt_r <= '0;
      seg_r  <= '0;
      hph_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      hcnt_r <= hcnt_nxt;
      row_r  <= row_nxt;
      tcnt_r <= tcnt_nxt;
      seg_r  <= seg_nxt;
      hph_r  <= hph_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Pixel routing and capture
  // --------------------------------------------------------------------------
  logic [33:0] pipe_r, pipe_nxt;
  logic        route_mem [0:1][0:`CCDT_COLS-1];
  logic        fg_win, out_win, dec, cur, old, m_valid, push, bank, ovr_r, ovr_nxt;
  logic [9:0]  col;
  logic [33:0] word;

  always_comb begin
    fg_win  = (st_r == ST_ROW) && hcnt_r >= `CCDT_FG_FIRST &&
              hcnt_r <= `CCDT_OUT_LAST - `CCDT_FG_LEAD;
    out_win = (st_r == ST_ROW) && hcnt_r >= `CCDT_OUT_FIRST &&
              hcnt_r <= `CCDT_OUT_LAST;
    // Small signals go through multiplication; the threshold is software's
    dec     = fg_win && (fg_s_r < threshold);
    pipe_nxt = (st_r == ST_ROW && tick) ? {pipe_r[32:0], dec} : pipe_r;
    cur     = pipe_r[33];
    col     = 10'(hcnt_r - `CCDT_OUT_FIRST);
    bank    = single ? 1'b0 : row_r[0];
    old     = route_mem[bank][col];
    // Multiplied samples trail by one row in single mode, two otherwise
    m_valid = old && (row_r >= (single ? 16'd1 : 16'd2));
    push    = out_win && tick && (!cur || m_valid);
    word    = {m_valid, ~cur, ml_s_r, nm_s_r};
    ovr_nxt = ovr_r;
    if (st_r == ST_IDLE && start) begin
      ovr_nxt = 1'b0;
    end
    if (push && !in_ready) begin
      ovr_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pipe_r <= '0;
      ovr_r  <= 1'b0;
    end else begin
      pipe_r <= pipe_nxt;
      ovr_r  <= ovr_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (out_win && tick) begin
      route_mem[bank][col] <= cur;
    end
  end

  logic [33:0] fifo_data;
  logic        fifo_valid;
  ccdt_fifo #(.W(34), .D(`CCDT_FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .in_valid (push),
    .in_ready (in_ready),
    .in_data  (word),
    .out_valid(fifo_valid),
    .out_ready(out_ready),
    .out_data (fifo_data)
  );
  assign out_valid = fifo_valid;
  assign out_data  = fifo_data;

  // --------------------------------------------------------------------------
  // Clock and control outputs
  // --------------------------------------------------------------------------
  logic [29:0] o_r, o_nxt;
  logic        run, p, b1a, b1b, quad;

  always_comb begin
    quad = (mode == CCDT_QUAD);
    // Horizontal clocks stop while amplifiers are off during long exposures
    run  = (st_nxt == ST_ROW) || (st_nxt == ST_FLUSH) || (st_nxt == ST_EXPOSE && !long_int);
    p    = hph_nxt;
    b1a  = reverse_a ? ~p : p;
    b1b  = (single ? ~p : p) ^ reverse_b;
    o_nxt = '0;
    if (run) begin
      o_nxt[0]  = p;                 o_nxt[1]  = ~p;
      o_nxt[2]  = b1a;               o_nxt[3]  = ~b1a;
      o_nxt[4]  = b1b;               o_nxt[5]  = ~b1b;
      o_nxt[6]  = quad ? p : 1'b1;   o_nxt[7]  = quad ? ~p : 1'b1;
      o_nxt[8]  = quad ? p : 1'b1;   o_nxt[9]  = quad ? ~p : 1'b1;
      o_nxt[10] = p;                 o_nxt[13] = ~p;
      o_nxt[14] = ~p;                o_nxt[15] = p;
      o_nxt[16] = ~p;                o_nxt[17] = p;
      o_nxt[18] = ~p;
    end else begin
      o_nxt[0]  = 1'b1;              o_nxt[2]  = 1'b1;
      o_nxt[4]  = 1'b1;              o_nxt[15] = 1'b1;
      o_nxt[17] = 1'b1;
      o_nxt[6]  = 1'b1;              o_nxt[7]  = 1'b1;
      o_nxt[8]  = 1'b1;              o_nxt[9]  = 1'b1;
    end
    o_nxt[11] = out_win && !tick && !pipe_nxt[33] && (st_nxt == ST_ROW);
    o_nxt[12] = out_win && !tick && pipe_nxt[33] && (st_nxt == ST_ROW);
    unique case (st_nxt)
      ST_LXFER: o_nxt[22:19] = 4'b0011 << seg_nxt | 4'b0011 >> (3'd4 - {1'b0, seg_nxt});
      ST_FXFER: o_nxt[22:19] = 4'b0101;
      default:  o_nxt[22:19] = 4'b0000;
    endcase
    o_nxt[23] = (st_nxt == ST_FXFER);
    o_nxt[24] = (st_nxt == ST_SHUT);
    o_nxt[25] = (st_nxt == ST_ROW) && hcnt_nxt >= `CCDT_CLAMP_FIRST &&
                hcnt_nxt < `CCDT_CLAMP_FIRST + `CCDT_CLAMP_LEN;
    o_nxt[26] = quad;
    o_nxt[27] = (st_nxt == ST_EXPOSE) && long_int;
    o_nxt[28] = (st_r == ST_IDLE) && start && long_int;
    o_nxt[29] = (st_nxt == ST_FLUSH);
  end

  logic busy_r, done_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      o_r    <= 30'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      o_r    <= o_nxt;
      busy_r <= (st_nxt != ST_IDLE);
      done_r <= done_nxt;
    end
  end

  assign first_storage_phase           = o_r[0];
  assign second_storage_phase          = o_r[1];
  assign first_barrier_phase_a         = o_r[2];
  assign second_barrier_phase_a        = o_r[3];
  assign first_barrier_phase_b         = o_r[4];
  assign second_barrier_phase_b        = o_r[5];
  assign upper_storage_one             = o_r[6];
  assign upper_storage_two             = o_r[7];
  assign upper_barrier_one             = o_r[8];
  assign upper_barrier_two             = o_r[9];
  assign charge_switch_phase           = o_r[10];
  assign route_normal_phase            = o_r[11];
  assign route_multiply_phase          = o_r[12];
  assign last_gate_phase               = o_r[13];
  assign exit_gate_phase               = o_r[14];
  assign first_multiply_storage_phase  = o_r[15];
  assign second_multiply_storage_phase = o_r[16];
  assign first_multiply_barrier_phase  = o_r[17];
  assign second_multiply_barrier_phase = o_r[18];
  assign vertical_phase                = o_r[22:19];
  assign transfer_pulse                = o_r[23];
  assign shutter_pulse                 = o_r[24];
  assign clamp                         = o_r[25];
  assign line_pattern_two              = o_r[26];
  assign amp_power_down                = o_r[27];
  assign substrate_reference_output_store                    = o_r[28];
  assign multiply_flush                = o_r[29];
  assign busy                          = busy_r;
  assign frame_done                    = done_r;
  assign overrun                       = ovr_r;
endmodule : ccdt_seq

// ### src/ccdt_consts.svh
// Timing counts and window positions for the image sensor readout sequencer
`ifndef CCDT_CONSTS_SVH
`define CCDT_CONSTS_SVH
// ----------------------------------------------------------------------------
// Row and frame geometry, in horizontal clock cycles and rows, plus data width in bits and FIFO depth in words
// ----------------------------------------------------------------------------
`define CCDT_NH_SINGLE   12'd2072
`define CCDT_NH_DUAL     12'd1036
`define CCDT_NV_SINGLE   16'd1124
`define CCDT_NV_DUAL     16'd562
`define CCDT_CLAMP_FIRST 12'd3
`define CCDT_CLAMP_LEN   12'd28
`define CCDT_FG_FIRST    12'd34
`define CCDT_OUT_FIRST   12'd68
`define CCDT_OUT_LAST    12'd1036
`define CCDT_FG_LEAD     12'd34
`define CCDT_COLS        969
`define CCDT_FLUSH_ROWS  16'd4
`define CCDT_DATA_W      16
`define CCDT_FIFO_DEPTH  16
// ----------------------------------------------------------------------------
// Pulse widths in ns and their core clock counts
// ----------------------------------------------------------------------------
`define CCDT_CLK_NS      10
`define CCDT_T_VA_NS     500
`define CCDT_T_VB_NS     1300
`define CCDT_T_XFER_NS   1500
`define CCDT_T_SUB_NS    1500
`define CCDT_VA_CYC      (`CCDT_T_VA_NS / `CCDT_CLK_NS)
`define CCDT_VB_CYC      (`CCDT_T_VB_NS / `CCDT_CLK_NS)
`define CCDT_XFER_CYC    (`CCDT_T_XFER_NS / `CCDT_CLK_NS)
`define CCDT_SUB_CYC     (`CCDT_T_SUB_NS / `CCDT_CLK_NS)
`endif

// ### src/ccdt_pkg.sv
// Types shared by the readout sequencer and its bench
package ccdt_pkg;
  typedef enum logic [1:0] {CCDT_SINGLE, CCDT_DUAL, CCDT_QUAD} ccdt_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SHUT, ST_EXPOSE, ST_FLUSH, ST_FXFER, ST_LXFER, ST_ROW} ccdt_state_t;
endpackage : ccdt_pkg

// ### testbench/ccdt_seq_assertions.sv
// Concurrent checks on the readout sequencer ports
`timescale 1ns/100ps
module ccdt_seq_assertions (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       start,
  input wire ccdt_pkg::ccdt_mode_t mode,
  input wire logic       shutter_en,
  input wire logic       long_int,
  input wire logic       reverse_a,
  input wire logic       reverse_b,
  input wire logic       first_storage_phase,
  input wire logic       second_storage_phase,
  input wire logic       first_barrier_phase_a,
  input wire logic       first_barrier_phase_b,
  input wire logic       upper_storage_one,
  input wire logic       upper_storage_two,
  input wire logic       upper_barrier_one,
  input wire logic       upper_barrier_two,
  input wire logic       charge_switch_phase,
  input wire logic       first_multiply_barrier_phase,
  input wire logic       second_multiply_barrier_phase,
  input wire logic [3:0] vertical_phase,
  input wire logic       transfer_pulse,
  input wire logic       shutter_pulse,
  input wire logic       clamp,
  input wire logic       substrate_reference_output_store,
  input wire logic       busy,
  input wire logic       out_valid,
  input wire logic       out_ready
);
  import ccdt_pkg::*;
  // ---------------------------------------------------------------------
  // Run lengths, counted so long pulses need no huge repetition
  // ---------------------------------------------------------------------
  logic [11:0] cl_r, cl_nxt, tp_r, tp_nxt, sp_r, sp_nxt, vc_r, vc_nxt;
  logic [3:0]  vl_r;
  always_comb begin
    cl_nxt = clamp ? cl_r + 12'h001 : 12'h000;
    tp_nxt = transfer_pulse ? tp_r + 12'h001 : 12'h000;
    sp_nxt = shutter_pulse ? sp_r + 12'h001 : 12'h000;
    vc_nxt = (vertical_phase == vl_r) ? vc_r + 12'h001 : 12'h001;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {cl_r, tp_r, sp_r, vc_r, vl_r} <= '0;
    end else begin
      {cl_r, tp_r, sp_r, vc_r, vl_r} <= {cl_nxt, tp_nxt, sp_nxt, vc_nxt, vertical_phase};
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_clamp_window: assert property ($fell(clamp) |-> cl_r == 12'h038) else $error("clamp length");
  a_xfer_width: assert property ($fell(transfer_pulse) |-> tp_r == 12'h096) else $error("transfer width");
  a_shut_width: assert property ($fell(shutter_pulse) |-> sp_r == 12'h096) else $error("shutter width");
  a_vert_a_time: assert property (vertical_phase != vl_r && (vl_r == 4'h3 || vl_r == 4'hc)
    |-> vc_r inside {[12'h02e:12'h032]}) else $error("vertical A time");
  a_vert_b_time: assert property (vertical_phase != vl_r && vl_r == 4'h6
    |-> vc_r inside {[12'h02e:12'h2ee]}) else $error("vertical B time");
  a_static_phases: assert property (transfer_pulse || shutter_pulse |-> first_storage_phase
    && !second_storage_phase && !charge_switch_phase && first_multiply_barrier_phase
    && !second_multiply_barrier_phase) else $error("static phases");
  a_upper_held: assert property ($past(nrst) && mode != CCDT_QUAD
    |-> upper_storage_one && upper_storage_two && upper_barrier_one && upper_barrier_two) else $error("upper gates");
  a_barrier_share: assert property (clamp
    |-> first_barrier_phase_a == (reverse_a ? second_storage_phase : first_storage_phase)
    && first_barrier_phase_b == (((mode != CCDT_SINGLE) ^ reverse_b) ? first_storage_phase : second_storage_phase))
    else $error("barrier sharing");
  a_frame_start: assert property (start && !busy
    |=> busy && (shutter_en ? shutter_pulse && !transfer_pulse : transfer_pulse)) else $error("frame start");
  a_substrate_reference_output_store: assert property (start && !busy && long_int |=> substrate_reference_output_store) else $error("reference store");
  c_row: cover property ($rose(clamp));
  c_xfer: cover property ($rose(transfer_pulse));
  c_pop: cover property (out_valid && out_ready);
endmodule : ccdt_seq_assertions

// ### testbench/ccdt_sensor_model.sv
// Behavioural sensor outputs: one pixel code per row on each output
`timescale 1ns/100ps
module ccdt_sensor_model (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire ccdt_pkg::ccdt_mode_t mode,
  input  wire logic                 busy,
  input  wire logic                 clamp,
  input  wire logic                 transfer_pulse,
  output logic [15:0]               fg_adc,
  output logic [15:0]               norm_adc,
  output logic [15:0]               mult_adc
);
  import ccdt_pkg::*;
  logic [15:0] row_r, lag;
  logic        cl_q, tp_q, xd;
  assign lag = (mode == CCDT_SINGLE) ? 16'h0001 : 16'h0002;
  // While the sequencer is not busy every output wanders so a stale sample never looks valid
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst || !busy) begin
      {row_r, xd} <= '0;
      fg_adc <= ~fg_adc;
      norm_adc <= norm_adc + 16'h1235;
      mult_adc <= ~norm_adc;
    end else begin
      if (tp_q && !transfer_pulse) xd <= 1'b1;
      if (clamp && !cl_q && xd) begin
        fg_adc <= row_r[0] ? 16'h0040 : 16'h4000;
        norm_adc <= 16'h2000 + row_r * 16'h0003;
        mult_adc <= (row_r >= lag) ? 16'h2000 + (row_r - lag) * 16'h0003 : ~mult_adc;
        row_r <= row_r + 16'h0001;
      end
    end
    cl_q <= clamp;
    tp_q <= transfer_pulse;
  end
endmodule : ccdt_sensor_model

// ### testbench/tb_ccdt_seq.sv
// Self-checking bench for the readout sequencer
`timescale 1ns/100ps
`include "ccdt_consts.svh"
module tb_ccdt_seq;
  import ccdt_pkg::*;
  ccdt_mode_t  mode;
  logic        core_clk, nrst, start, shutter_en, long_int, reverse_a, reverse_b, out_ready, out_valid, hold;
  logic [15:0] threshold, exposure_lines, fg_adc, norm_adc, mult_adc;
  logic [33:0] out_data, eq[$], mq[$];
  logic [31:0] rs;
  logic        first_storage_phase, second_storage_phase, first_barrier_phase_a, second_barrier_phase_a;
  logic        first_barrier_phase_b, second_barrier_phase_b, upper_storage_one, upper_storage_two;
  logic        upper_barrier_one, upper_barrier_two, charge_switch_phase, route_normal_phase, route_multiply_phase;
  logic        last_gate_phase, exit_gate_phase, first_multiply_storage_phase, second_multiply_storage_phase;
  logic        first_multiply_barrier_phase, second_multiply_barrier_phase, transfer_pulse, shutter_pulse, clamp;
  logic        line_pattern_two, amp_power_down, substrate_reference_output_store, multiply_flush, busy, frame_done, overrun;
  logic        cl_q, tp_q, xd, s_fl, s_pd, s_l2;
  logic [3:0]  vertical_phase;
  int          err_count, n_tests, row;
  ccdt_seq ccdt_seq_i (.*);
  ccdt_sensor_model ccdt_sensor_model_i (.core_clk, .nrst, .mode, .busy, .clamp, .transfer_pulse,
    .fg_adc, .norm_adc, .mult_adc);
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #(95000 * 10);
    err_count++;
    stop_test();
  end
  always @(negedge core_clk) begin
    rs = xs(rs);
    out_ready <= !hold && rs[1:0] != 2'b00;
  end
  // Expected words of a row are queued at its clamp, before any pixel
  always @(posedge core_clk) begin : mon
    logic mv, nv;
    int   lag;
    lag = (mode == CCDT_SINGLE) ? 1 : 2;
    if (!nrst) begin
      eq.delete();
      mq.delete();
    end
    if (!busy) begin
      xd <= 1'b0;
      row <= 0;
    end else if (tp_q && !transfer_pulse) xd <= 1'b1;
    if (clamp && !cl_q && xd) begin
      nv = row[0] == 1'b0;
      mv = row >= lag && row[0] != lag[0];
      for (int c = 0; c < `CCDT_COLS && (nv || mv); c++) begin
        eq.push_back({mv, nv, mv ? 16'h2000 + 16'((row - lag) * 3) : 16'h0, nv ? 16'h2000 + 16'(row * 3) : 16'h0});
        mq.push_back({2'b11, {16{mv}}, {16{nv}}});
      end
      row <= row + 1;
    end
    cl_q <= clamp;
    tp_q <= transfer_pulse;
    s_fl <= s_fl | multiply_flush;
    s_pd <= s_pd | amp_power_down;
    s_l2 <= s_l2 | line_pattern_two;
    if (out_valid && out_ready && nrst) begin
      if (eq.size() == 0) check("word count", 34'h1, 34'(eq.size()));
      else begin
        check("pixel word", eq[0], out_data & mq[0]);
        eq.delete(0);
        mq.delete(0);
      end
    end
  end
  task automatic frame(input ccdt_mode_t m, input logic sh, li, ra, rb, st, input int rows);
    int t;
    nrst = 1'b0;
    mode = m;
    {shutter_en, long_int, reverse_a, reverse_b} = {sh, li, ra, rb};
    {s_fl, s_pd, s_l2} = 3'b000;
    threshold = 16'h0100 + {3'b000, rs[12:0]};
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    start = 1'b1;
    for (t = 0; row < rows && t < 60000; t++) begin
      @(negedge core_clk);
      start = (t == 2500);
    end
    hold = st;
    repeat (st ? 600 : 1) @(negedge core_clk);
    check("rows reached", 1'b1, row >= rows);
    check("flush seen", li, s_fl);
    check("power down seen", li, s_pd);
    check("pattern two seen", m == CCDT_QUAD, s_l2);
    check("overrun", st, overrun);
    if (st) check("words held", 1'b1, out_valid);
  endtask : frame
  initial begin
    {nrst, start, hold, rs} = {3'b000, 32'd66331};
    mode = CCDT_DUAL;
    {shutter_en, long_int, reverse_a, reverse_b} = 4'h0;
    {threshold, exposure_lines, out_ready} = {16'h0100, 16'h0001, 1'b0};
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    check("idle upper gate", 1'b1, upper_barrier_two);
    check("idle busy", 1'b0, busy);
    check("idle out_valid", 1'b0, out_valid);
    check("idle overrun", 1'b0, overrun);
    frame(CCDT_DUAL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5);
    frame(CCDT_SINGLE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4);
    frame(CCDT_QUAD, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3);
    stop_test();
  end
endmodule : tb_ccdt_seq

bind ccdt_seq ccdt_seq_assertions ccdt_seq_assertions_i (.*);
